//--- include/ring_map.svh
/*
  Constants for the descriptor ring handler: register offsets, control
  and status bit positions, descriptor field positions, frame limits.
  Assumes: included by bare name; defines only.
*/
// How it works
// R1 - descriptor holds buffer and next pointers
// R2 - rx owner bit 31 cleared on close
// R3 - rx byte count into word0 29:16
// R4 - rx status only in last descriptor
// R5 - rx error summary ORs six faults
// R6 - buffer_starved when frame truncated for buffers
// R7 - bits 13:12 checksum failures or path
// R8 - short_frame under 64 bytes, overflow clear
// R9 - multicast, first and last segment marks
// R10 - oversize beyond 1518 bytes, late collision
// R11 - bits 5:3 checksum kinds or legacy flags
// R12 - alignment, crc fail, overflow in 2:0
// R13 - host sets rx size, bit24 one
// R14 - host aligns buffer and next pointers
// R15 - tx owner cleared after buffer sent
// R16 - tx error summary; jabber sets status bit
// R17 - carrier lost, no carrier, late collision
// R18 - abort at 16 collisions; collision tally
// R19 - underrun abort, underrun seen, deferral
// R20 - completion request for last or setup
// R21 - tx control word marks and length
// R22 - setup frame selects filter type
// R23 - rx suspends on host-owned descriptor
// R24 - walk next pointers from list base
`ifndef RING_MAP_SVH
`define RING_MAP_SVH
// ==================================================
// register map
`define OFS_CTRL 8'h00
`define OFS_TX_POLL 8'h04
`define OFS_RX_POLL 8'h08
`define OFS_RX_BASE 8'h0C
`define OFS_TX_BASE 8'h10
`define OFS_NET_STATUS 8'h14
`define OFS_WDJ 8'h18
`define CTRL_RX_RUN 0
`define CTRL_TX_RUN 1
`define WDJ_CSUM 27
`define NS_RX_WDOG 9
`define NS_JABBER 3
`define NS_TX_DONE 0
`define NS_RX_SUSP 16
`define NS_TX_SUSP 17
`define RST_WORD 32'h0000_0000
// ==================================================
// descriptor layout
`define DW_STAT 2'h0
`define DW_CTL 2'h1
`define DW_BUF 2'h2
`define DW_NEXT 2'h3
`define WORD_STEP 32'h0000_0004
`define OWN_BIT 31
`define AUN_BIT 30
`define LEN_HI 29
`define LEN_LO 16
`define RX_ES 15
`define RX_STARVE 14
`define RX_CS_HI 13
`define RX_CS_LO 12
`define RX_SHORT 11
`define RX_MCAST 10
`define RX_FIRST 9
`define RX_LAST 8
`define RX_BIG 7
`define RX_LATE 6
`define RX_K_HI 5
`define RX_K_LO 3
`define RX_ALIGN 2
`define RX_CRC 1
`define RX_OVF 0
`define TX_ES 15
`define TX_JAB 14
`define TX_UR_SEEN 12
`define TX_LOST 11
`define TX_NOCAR 10
`define TX_LATE 9
`define TX_LIMIT 8
`define TX_CC_HI 6
`define TX_CC_LO 3
`define TX_UR_ABORT 1
`define TX_DEFER 0
`define C_IRQ 31
`define C_LAST 30
`define C_FIRST 29
`define C_FT_HI 28
`define C_SETUP 27
`define C_CRC_OFF 26
`define C_PAD_OFF 23
`define C_FT_LO 22
`define C_LEN_HI 10
`define SETUP_CLOSE 32'h7FFF_FFFF
`define SHORT_LEN 14'h0040
`define LONG_LEN 14'h05EE
`define COLL_LIMIT 5'h10
`endif

//--- include/ring_pkg.sv
/*
  Types for the descriptor ring handler: descriptor image, receive
  segment report, transmit result, buffer offers, state enums.
  Assumes: compiled before any design module.
*/
package ring_pkg;
  typedef struct packed {
    logic [31:0] next;
    logic [31:0] buf_addr;
    logic [31:0] ctl;
    logic [31:0] stat;
  } desc_t;
  typedef struct packed {
    logic last;
    logic [13:0] bytes;
    logic addr_miss;
    logic multicast;
    logic [1:0] path;
    logic ip_bad;
    logic l4_bad;
    logic late_col;
    logic crc_fail;
    logic overflow;
    logic align;
    logic ethertype;
    logic wdog;
    logic phy_err;
    logic is_ip;
    logic is_tcp;
    logic is_udp;
  } rx_seg_t;
  typedef struct packed {
    logic jabber;
    logic carrier_lost;
    logic no_carrier;
    logic late_col;
    logic [4:0] collisions;
    logic underrun_seen;
    logic underrun_abort;
    logic deferred;
  } tx_result_t;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [10:0] size;
  } rx_buf_t;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [10:0] len;
    logic first;
    logic last;
    logic crc_off;
    logic pad_off;
  } tx_buf_t;
  typedef enum logic [2:0] {R_STOP, R_FETCH, R_CLOSE, R_WAIT, R_SUSP} rx_state_t;
  typedef enum logic [2:0] {T_STOP, T_FETCH, T_WAIT, T_CLOSE, T_SUSP} tx_state_t;
  typedef enum logic [1:0] {W_IDLE, W_READ, W_WRITE} walk_state_t;
endpackage

//--- hdl/desc_walker.sv
/*
  Descriptor walker: reads the four words of one descriptor, or writes
  its status word, over the host memory port.
  Assumes: memory answers each word with a one-cycle mem_ack while
  mem_req is high; all inputs on hclk.
*/
`timescale 1ns/10ps
`include "ring_map.svh"
module desc_walker
  import ring_pkg::*;
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset
  input wire logic ce, // clock enable
  input wire logic start, // begin an operation
  input wire logic wr, // 1 writes status word
  input wire logic [31:0] addr, // descriptor address
  input wire logic [31:0] wdata, // status to write
  output logic busy, // operation running
  output logic done, // operation ended
  output desc_t desc, // words read
  output logic mem_req, // memory request
  output logic mem_we, // memory write
  output logic [31:0] mem_addr, // memory address
  output logic [31:0] mem_wdata, // memory write data
  input wire logic mem_ack, // word taken
  input wire logic [31:0] mem_rdata // memory read data
);
  walk_state_t st_q;
  logic [1:0] idx_q;
  logic last_ack;

  assign busy = (st_q != W_IDLE);
  assign last_ack = mem_ack && (st_q == W_WRITE || idx_q == `DW_NEXT);

  // ==================================================
  // sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= W_IDLE;
      idx_q <= `DW_STAT;
      done <= 1'b0;
    end else if (ce) begin
      done <= busy && last_ack;
      case (st_q)
        W_IDLE: begin
          if (start) begin
            st_q <= wr ? W_WRITE : W_READ;
            idx_q <= `DW_STAT;
          end
        end
        W_READ, W_WRITE: begin
          if (mem_ack) begin
            idx_q <= idx_q + 2'h1;
          end
          if (last_ack) begin
            st_q <= W_IDLE;
          end
        end
        default: st_q <= W_IDLE;
      endcase
    end
  end

  // ==================================================
  // memory port; request stays up across the four reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `RST_WORD;
      mem_wdata <= `RST_WORD;
    end else if (ce) begin
      if (!busy && start) begin
        mem_req <= 1'b1;
        mem_we <= wr;
        mem_addr <= addr;
        mem_wdata <= wdata;
      end else if (busy && mem_ack) begin
        mem_req <= !last_ack;
        mem_addr <= mem_addr + `WORD_STEP;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc <= '0;
    end else if (ce && st_q == W_READ && mem_ack) begin
      case (idx_q)
        `DW_STAT: desc.stat <= mem_rdata;
        `DW_CTL: desc.ctl <= mem_rdata;
        `DW_BUF: desc.buf_addr <= mem_rdata;
        `DW_NEXT: desc.next <= mem_rdata; // see R1
        default: desc.stat <= mem_rdata;
      endcase
    end
  end
endmodule

//--- hdl/ring_handler.sv
/*
  Descriptor ring handler: walks chained receive and transmit descriptor
  lists in host memory, offers buffers to the MAC data paths and closes
  descriptors with frame status. Registers on an AHB-Lite slave.
  Assumes: all inputs on hclk; host keeps buffers and next pointers
  aligned and writes word1 bit 24 as one.
*/
`timescale 1ns/10ps
`include "ring_map.svh"
module ring_handler
  import ring_pkg::*;
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // never stalls
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  output logic mem_req, // memory request
  output logic mem_we, // memory write
  output logic [31:0] mem_addr, // memory address
  output logic [31:0] mem_wdata, // memory write data
  input wire logic mem_ack, // word taken
  input wire logic [31:0] mem_rdata, // memory read data
  output rx_buf_t rx_buf, // receive buffer offer
  input wire logic rx_seg_valid, // segment ended
  input wire rx_seg_t rx_seg, // segment report
  output logic rx_drop, // truncate frame
  output tx_buf_t tx_buf, // transmit buffer offer
  input wire logic tx_sent, // buffer sent
  input wire tx_result_t tx_res, // send result
  output logic [1:0] filter_mode, // address filter type
  output logic filter_load // setup frame taken
);
  rx_state_t rs_q;
  rx_state_t rx_after_q;
  tx_state_t ts_q;
  tx_state_t tx_after_q;
  logic acc, wr_q, rx_run_q, tx_run_q, csum_q;
  logic [7:0] wa_q;
  logic [31:0] rx_base_q, tx_base_q, rd_v;
  logic ns_rxwd_q, ns_jab_q, ns_txdone_q;
  logic rx_poll, tx_poll, ns_wr;
  logic [31:0] rx_cur_q, rx_addr_q, rx_word_q;
  logic [31:0] tx_cur_q, tx_word_q;
  desc_t rx_desc_q, tx_desc_q, w_desc;
  logic first_q, pend_q, pend_first_q;
  logic [31:0] pend_addr_q;
  rx_seg_t pend_seg_q;
  logic tx_ci_q, tx_abort;
  logic rx_need, tx_need, go_rx, go_tx, rx_iss_q, tx_iss_q, own_tx_q;
  logic w_busy, w_done, rx_done, tw_done;
  logic [31:0] w_addr, w_wdata;

  // ==================================================
  // status word builders
  function automatic logic [31:0] mk_rx(rx_seg_t s, logic first, logic last,
                                        logic starve, logic cs);
    logic [31:0] w;
    logic shrt;
    logic big;
    w = '0;
    shrt = (s.bytes < `SHORT_LEN) && !s.overflow; // see R8
    big = (s.bytes > `LONG_LEN); // see R10
    w[`LEN_HI:`LEN_LO] = s.bytes; // see R3
    w[`RX_FIRST] = first; // see R9
    w[`RX_LAST] = last; // see R9
    if (last) begin // see R4
      w[`AUN_BIT] = s.addr_miss;
      w[`RX_ES] = starve | shrt | big | s.late_col | s.crc_fail | s.overflow; // see R5
      w[`RX_STARVE] = starve; // see R6
      w[`RX_CS_HI:`RX_CS_LO] = cs ? {s.ip_bad, s.l4_bad} : s.path; // see R7
      w[`RX_SHORT] = shrt; // see R8
      w[`RX_MCAST] = s.multicast; // see R9
      w[`RX_BIG] = big; // see R10
      w[`RX_LATE] = s.late_col; // see R10
      w[`RX_K_HI:`RX_K_LO] = cs ? {s.is_ip, s.is_tcp, s.is_udp}
                                : {s.ethertype, s.wdog, s.phy_err}; // see R11
      w[`RX_ALIGN] = s.align; // see R12
      w[`RX_CRC] = s.crc_fail; // see R12
      w[`RX_OVF] = s.overflow; // see R12
    end
    return w;
  endfunction

  function automatic logic [31:0] mk_tx(tx_result_t r);
    logic [31:0] w;
    logic lim;
    w = '0;
    lim = (r.collisions >= `COLL_LIMIT); // see R18
    w[`TX_ES] = r.jabber | r.carrier_lost | r.no_carrier | r.late_col | lim
                | r.underrun_abort; // see R16
    w[`TX_JAB] = r.jabber; // see R16
    w[`TX_UR_SEEN] = r.underrun_seen; // see R19
    w[`TX_LOST] = r.carrier_lost; // see R17
    w[`TX_NOCAR] = r.no_carrier; // see R17
    w[`TX_LATE] = r.late_col; // see R17
    w[`TX_LIMIT] = lim; // see R18
    w[`TX_CC_HI:`TX_CC_LO] = r.collisions[3:0]; // see R18
    w[`TX_UR_ABORT] = r.underrun_abort; // see R19
    w[`TX_DEFER] = r.deferred; // see R19
    return w;
  endfunction

  // ==================================================
  // bus slave: zero wait, read data captured in the address phase
  assign acc = hsel && hready && htrans[1];
  assign rx_poll = wr_q && wa_q == `OFS_RX_POLL;
  assign tx_poll = wr_q && wa_q == `OFS_TX_POLL;
  assign ns_wr = wr_q && wa_q == `OFS_NET_STATUS;

  always_comb begin
    rd_v = '0;
    case (haddr[7:0])
      `OFS_CTRL: begin
        rd_v[`CTRL_RX_RUN] = rx_run_q;
        rd_v[`CTRL_TX_RUN] = tx_run_q;
      end
      `OFS_RX_BASE: rd_v = rx_base_q;
      `OFS_TX_BASE: rd_v = tx_base_q;
      `OFS_WDJ: rd_v[`WDJ_CSUM] = csum_q;
      `OFS_NET_STATUS: begin
        rd_v[`NS_RX_WDOG] = ns_rxwd_q;
        rd_v[`NS_JABBER] = ns_jab_q;
        rd_v[`NS_TX_DONE] = ns_txdone_q;
        rd_v[`NS_RX_SUSP] = (rs_q == R_SUSP);
        rd_v[`NS_TX_SUSP] = (ts_q == T_SUSP);
      end
      default: rd_v = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= `OFS_CTRL;
      hrdata <= `RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      wr_q <= acc && hwrite;
      if (acc) begin
        wa_q <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata <= rd_v;
      end
    end
  end

  // ==================================================
  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_run_q <= 1'b0;
      tx_run_q <= 1'b0;
      rx_base_q <= `RST_WORD;
      tx_base_q <= `RST_WORD;
      csum_q <= 1'b0;
    end else if (ce && wr_q) begin
      case (wa_q)
        `OFS_CTRL: begin
          rx_run_q <= hwdata[`CTRL_RX_RUN];
          tx_run_q <= hwdata[`CTRL_TX_RUN];
        end
        `OFS_RX_BASE: rx_base_q <= hwdata;
        `OFS_TX_BASE: tx_base_q <= hwdata;
        `OFS_WDJ: csum_q <= hwdata[`WDJ_CSUM];
        default: csum_q <= csum_q;
      endcase
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ns_rxwd_q <= 1'b0;
      ns_jab_q <= 1'b0;
      ns_txdone_q <= 1'b0;
    end else if (ce) begin
      ns_rxwd_q <= (rx_seg_valid && rs_q == R_WAIT && rx_seg.last && !csum_q && rx_seg.wdog)
                   || (ns_rxwd_q && !(ns_wr && hwdata[`NS_RX_WDOG])); // see R11
      ns_jab_q <= (tx_sent && ts_q == T_WAIT && tx_res.jabber)
                  || (ns_jab_q && !(ns_wr && hwdata[`NS_JABBER])); // see R16
      ns_txdone_q <= (tw_done && ts_q == T_CLOSE && tx_ci_q)
                     || (ns_txdone_q && !(ns_wr && hwdata[`NS_TX_DONE])); // see R20
    end
  end

  // ==================================================
  // shared walker; receive wins a tie since its FIFO can overflow
  assign rx_need = (rs_q == R_FETCH || rs_q == R_CLOSE) && !rx_iss_q;
  assign tx_need = (ts_q == T_FETCH || ts_q == T_CLOSE) && !tx_iss_q;
  assign go_rx = !w_busy && rx_need;
  assign go_tx = !w_busy && !rx_need && tx_need;
  assign rx_done = w_done && !own_tx_q;
  assign tw_done = w_done && own_tx_q;
  assign w_addr = go_rx ? ((rs_q == R_CLOSE) ? rx_addr_q : rx_cur_q)
                        : ((ts_q == T_CLOSE) ? tx_desc_q.stat : tx_cur_q);
  assign w_wdata = go_rx ? rx_word_q : tx_word_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_iss_q <= 1'b0;
      tx_iss_q <= 1'b0;
      own_tx_q <= 1'b0;
    end else if (ce) begin
      rx_iss_q <= go_rx || (rx_iss_q && !rx_done);
      tx_iss_q <= go_tx || (tx_iss_q && !tw_done);
      if (go_rx || go_tx) begin
        own_tx_q <= go_tx;
      end
    end
  end

  desc_walker walker (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(go_rx || go_tx),
    .wr(go_rx ? (rs_q == R_CLOSE) : (ts_q == T_CLOSE)),
    .addr(w_addr),
    .wdata(w_wdata),
    .busy(w_busy),
    .done(w_done),
    .desc(w_desc),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // ==================================================
  // receive sequencer; a non-last segment is closed only once the next
  // descriptor is known, so a missing buffer can mark it truncated
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs_q <= R_STOP;
      rx_after_q <= R_STOP;
      rx_cur_q <= `RST_WORD;
      rx_addr_q <= `RST_WORD;
      rx_word_q <= `RST_WORD;
      rx_desc_q <= '0;
      first_q <= 1'b1;
      pend_q <= 1'b0;
      pend_first_q <= 1'b0;
      pend_addr_q <= `RST_WORD;
      pend_seg_q <= '0;
      rx_drop <= 1'b0;
    end else if (ce) begin
      rx_drop <= 1'b0;
      case (rs_q)
        R_STOP: begin
          if (rx_run_q) begin
            rx_cur_q <= rx_base_q; // see R24
            first_q <= 1'b1;
            rs_q <= R_FETCH;
          end
        end
        R_FETCH: begin
          if (rx_done) begin
            rx_desc_q <= w_desc;
            pend_q <= 1'b0;
            rx_addr_q <= pend_addr_q;
            if (w_desc.stat[`OWN_BIT]) begin // see R2
              if (pend_q) begin
                rx_word_q <= mk_rx(pend_seg_q, pend_first_q, 1'b0, 1'b0, csum_q);
                rx_after_q <= R_WAIT;
                rs_q <= R_CLOSE;
              end else begin
                rs_q <= R_WAIT;
              end
            end else if (pend_q) begin
              rx_word_q <= mk_rx(pend_seg_q, pend_first_q, 1'b1, 1'b1, csum_q); // see R6
              rx_drop <= 1'b1;
              first_q <= 1'b1;
              rx_after_q <= R_SUSP;
              rs_q <= R_CLOSE;
            end else begin
              rs_q <= R_SUSP; // see R23
            end
          end
        end
        R_CLOSE: begin
          if (rx_done) begin
            rs_q <= rx_after_q;
          end
        end
        R_WAIT: begin
          if (rx_seg_valid) begin
            rx_cur_q <= rx_desc_q.next; // see R24
            rx_addr_q <= rx_cur_q;
            rx_word_q <= mk_rx(rx_seg, first_q, 1'b1, 1'b0, csum_q);
            first_q <= rx_seg.last;
            pend_q <= !rx_seg.last;
            pend_seg_q <= rx_seg;
            pend_first_q <= first_q;
            pend_addr_q <= rx_cur_q;
            rx_after_q <= R_FETCH;
            rs_q <= rx_seg.last ? R_CLOSE : R_FETCH;
          end else if (!rx_run_q) begin
            rs_q <= R_STOP;
          end
        end
        R_SUSP: begin
          if (!rx_run_q) begin
            rs_q <= R_STOP;
          end else if (rx_poll) begin
            rs_q <= R_FETCH;
          end
        end
        default: rs_q <= R_STOP;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf <= '0;
    end else if (ce) begin
      rx_buf.valid <= (rs_q == R_WAIT) && !rx_seg_valid && rx_run_q;
      rx_buf.addr <= rx_desc_q.buf_addr;
      rx_buf.size <= rx_desc_q.ctl[`C_LEN_HI:0]; // see R13
    end
  end

  // ==================================================
  // transmit sequencer; tx_desc_q.stat is reused to hold the
  // address of the descriptor being closed
  assign tx_abort = tx_res.jabber || tx_res.underrun_abort
                    || (tx_res.collisions >= `COLL_LIMIT); // see R18

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_q <= T_STOP;
      tx_after_q <= T_STOP;
      tx_cur_q <= `RST_WORD;
      tx_word_q <= `RST_WORD;
      tx_desc_q <= '0;
      tx_ci_q <= 1'b0;
      filter_mode <= 2'h0;
      filter_load <= 1'b0;
    end else if (ce) begin
      filter_load <= 1'b0;
      case (ts_q)
        T_STOP: begin
          if (tx_run_q) begin
            tx_cur_q <= tx_base_q; // see R24
            ts_q <= T_FETCH;
          end
        end
        T_FETCH: begin
          if (tw_done) begin
            tx_desc_q <= w_desc;
            tx_desc_q.stat <= tx_cur_q;
            if (!w_desc.stat[`OWN_BIT]) begin // see R15
              ts_q <= T_SUSP;
            end else if (w_desc.ctl[`C_SETUP]) begin // see R21
              filter_mode <= {w_desc.ctl[`C_FT_HI], w_desc.ctl[`C_FT_LO]}; // see R22
              filter_load <= 1'b1;
              tx_word_q <= `SETUP_CLOSE;
              tx_ci_q <= w_desc.ctl[`C_IRQ]; // see R20
              tx_cur_q <= w_desc.next; // see R1
              tx_after_q <= T_FETCH;
              ts_q <= T_CLOSE;
            end else begin
              tx_ci_q <= w_desc.ctl[`C_IRQ] && w_desc.ctl[`C_LAST]; // see R20
              ts_q <= T_WAIT;
            end
          end
        end
        T_WAIT: begin
          if (tx_sent) begin
            tx_word_q <= mk_tx(tx_res); // see R15
            tx_cur_q <= tx_desc_q.next; // see R24
            tx_after_q <= tx_abort ? T_SUSP : T_FETCH;
            ts_q <= T_CLOSE;
          end else if (!tx_run_q) begin
            ts_q <= T_STOP;
          end
        end
        T_CLOSE: begin
          if (tw_done) begin
            ts_q <= tx_after_q;
          end
        end
        T_SUSP: begin
          if (!tx_run_q) begin
            ts_q <= T_STOP;
          end else if (tx_poll) begin
            ts_q <= T_FETCH;
          end
        end
        default: ts_q <= T_STOP;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf <= '0;
    end else if (ce) begin
      tx_buf.valid <= (ts_q == T_WAIT) && !tx_sent && tx_run_q;
      tx_buf.addr <= tx_desc_q.buf_addr;
      tx_buf.len <= tx_desc_q.ctl[`C_LEN_HI:0]; // see R21
      tx_buf.first <= tx_desc_q.ctl[`C_FIRST];
      tx_buf.last <= tx_desc_q.ctl[`C_LAST];
      tx_buf.crc_off <= tx_desc_q.ctl[`C_CRC_OFF] && tx_desc_q.ctl[`C_FIRST]; // see R21
      tx_buf.pad_off <= tx_desc_q.ctl[`C_PAD_OFF];
    end
  end
endmodule

//--- verif/ring_mem_model.sv
/* host memory model for descriptor traffic.
   assumes one request at a time, all on hclk. */
`timescale 1ns/10ps
module ring_mem_model (
  input wire logic hclk, // clock
  input wire logic mem_req, // request
  input wire logic mem_we, // write
  input wire logic [31:0] mem_addr, // address
  input wire logic [31:0] mem_wdata, // wdata
  output logic mem_ack = 1'h0, // taken
  output logic [31:0] mem_rdata // rdata
);
  // ==========
  // storage, chains and alignment kept by the host
  logic [31:0] m [0:255];
  logic [1:0] cnt_q = 2'h0;
  // off an ack the bus shows junk, never the held word
  assign mem_rdata = mem_ack ? m[mem_addr[9:2]] : ~m[mem_addr[9:2]];
  always @(posedge hclk) begin
    mem_ack <= 1'h0;
    if (mem_req && !mem_ack && cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end else if (mem_req && !mem_ack) begin
      mem_ack <= 1'h1;
      // gap varies with the word, so answers come both prompt and slow
      cnt_q <= mem_addr[3:2];
      if (mem_we) m[mem_addr[9:2]] <= mem_wdata;
    end
  end
endmodule

//--- verif/ring_handler_sva.sv
/* checker on ring_handler ports.
   assumes bind from the bench, ce held high. */
`timescale 1ns/10ps
module ring_handler_sva
  import ring_pkg::*;
(
  input wire logic hclk, // clk
  input wire logic hresetn, // rst
  input wire logic hreadyout, // ready
  input wire logic mem_req, // req
  input wire logic mem_we, // write
  input wire logic mem_ack, // ack
  input wire logic [31:0] mem_addr, // addr
  input wire logic [31:0] mem_wdata, // wdata
  input wire rx_buf_t rx_buf, // rx offer
  input wire logic rx_seg_valid, // rx end
  input wire tx_buf_t tx_buf, // tx offer
  input wire logic tx_sent // tx end
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // port relations
  sequence rd_taken; mem_req && mem_ack && !mem_we; endsequence
  sequence close_wr; mem_req && mem_we; endsequence
  bus_ready_a: assert property (hreadyout) else $error("bus stalled");
  word_step_a: assert property (
    rd_taken ##0 mem_addr[3:2] != 2'h3 |=> mem_req && mem_addr == $past(mem_addr) + 32'h4)
    else $error("fetch address skipped");
  req_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("request dropped early");
  one_write_a: assert property (
    close_wr ##0 mem_ack |=> !mem_req) else $error("close wrote twice");
  own_clear_a: assert property (
    close_wr |-> !mem_wdata[31]) else $error("close left owner set");
  rx_take_a: assert property (
    rx_seg_valid && rx_buf.valid |=> !rx_buf.valid ##[0:60] close_wr)
    else $error("rx segment not closed");
  tx_take_a: assert property (
    tx_sent && tx_buf.valid |=> !tx_buf.valid ##[0:60] close_wr)
    else $error("tx buffer not closed");
  offer_hold_a: assert property (
    rx_buf.valid && !rx_seg_valid |=> !rx_buf.valid || $stable(rx_buf))
    else $error("rx offer moved");
endmodule

//--- verif/ring_handler_tb.sv
/* bench for the ring handler: AHB register tasks, host memory model.
   assumes ring_pkg, checker and model compiled first. */
`timescale 1ns/10ps
module ring_handler_tb
  import ring_pkg::*;
;
  logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, tx_sent = 1'h0, rx_seg_valid = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, mem_addr, mem_wdata, mem_rdata;
  logic [1:0] htrans = 2'h0, filter_mode;
  logic hreadyout, hresp, mem_req, mem_we, mem_ack, rx_drop, filter_load;
  rx_buf_t rx_buf;
  tx_buf_t tx_buf;
  rx_seg_t rx_seg = '0;
  tx_result_t tx_res = '0;
  int miscompares = 0, n_compared = 0, k;
  // rx 0x40 then 0x60 host owned; tx setup 0x80, frame 0xA0, 0xC0 host owned
  logic [31:0] img [0:19] = '{32'h80000000, 32'h01000200, 32'h400, 32'h60,
    32'h0, 32'h01000200, 32'h600, 32'h40, 32'h80000000, 32'h990000C0, 32'h700, 32'hA0,
    32'h80000000, 32'h6180003C, 32'h800, 32'hC0, 32'h0, 32'h01000000, 32'h900, 32'h80};
  always #2.5 hclk = ~hclk;
  ring_handler u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .rx_buf(rx_buf), .rx_seg_valid(rx_seg_valid), .rx_seg(rx_seg), .rx_drop(rx_drop),
    .tx_buf(tx_buf), .tx_sent(tx_sent), .tx_res(tx_res), .filter_mode(filter_mode),
    .filter_load(filter_load));
  ring_mem_model u_mem (.hclk(hclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ==========
  // tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic chk(input logic [47:0] e, input logic [47:0] g, input string nm);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic susp(input int b);
    q = 32'h0;
    for (k = 0; k < 60 && q[b] !== 1'h1; k++) bus(1'h0, 8'h14, 32'h0);
  endtask
  task automatic complete_run();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    for (k = 0; k < 20; k++) u_mem.m[16 + k / 4 * 8 + k % 4] = img[k];
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, 8'h40, 32'h0);
    chk(48'h0, {hresp, q}, "unmapped");
    bus(1'h1, 8'h0C, 32'h40);
    bus(1'h1, 8'h10, 32'h80);
    bus(1'h1, 8'h00, 32'h1);
    for (k = 0; k < 99 && rx_buf.valid !== 1'h1; k++) @(posedge hclk);
    chk({1'h1, 32'h400, 11'h200}, rx_buf, "rx offer");
    rx_seg_valid <= 1'h1;
    rx_seg <= '{last: 1'h1, bytes: 14'h3C, crc_fail: 1'h1, default: 1'h0};
    @(posedge hclk);
    rx_seg_valid <= 1'h0;
    susp(16);
    chk(32'h003C8B02, u_mem.m[16], "rx close");
    bus(1'h1, 8'h00, 32'h3);
    for (k = 0; k < 99 && filter_load !== 1'h1; k++) @(posedge hclk);
    @(posedge hclk);
    chk(48'h2, filter_mode, "filter");
    for (k = 0; k < 99 && tx_buf.valid !== 1'h1; k++) @(posedge hclk);
    chk({1'h1, 32'h800, 11'h3C, 4'hD}, tx_buf, "tx offer");
    tx_sent <= 1'h1;
    tx_res <= '{collisions: 5'h3, deferred: 1'h1, default: 1'h0};
    @(posedge hclk);
    tx_sent <= 1'h0;
    susp(17);
    chk(32'h7FFFFFFF, u_mem.m[32], "setup close");
    chk(32'h00000019, u_mem.m[40], "tx close");
    chk(32'h00030001, q & 32'h00030001, "status");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    complete_run();
  end
endmodule
bind ring_handler ring_handler_sva u_sva (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .mem_req(mem_req), .mem_we(mem_we), .mem_ack(mem_ack),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rx_buf(rx_buf), .rx_seg_valid(rx_seg_valid),
  .tx_buf(tx_buf), .tx_sent(tx_sent));
